// ===== src/xoe_core.sv
// Behaviour
// - Literal XOR into accumulator, flags updated
// - File XOR with accumulator, one cycle
// - Destination bit selects accumulator or file
// - Bank bit selects access or banked RAM
// - Access below 0x60 with extension: indexed offset
// - Extension disabled unless fuse bit set
// - Third pointer add/subtract then return
// - Extended ops are pointer literal operations
// - Stack add/sub return: two cycles, flags kept
`default_nettype none
module xoe_core
  import xoe_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Instruction stream.
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic        extension_enable_fuse,
  input  wire logic [5:0]  bank_select_register,
  // Data memory port.
  input  wire logic [7:0]  file_rdata,
  output var  logic [13:0] file_addr,
  output var  logic [7:0]  file_wdata,
  output var  logic        file_we,
  // Core state.
  output var  logic [7:0]  accumulator,
  output var  logic        neg_flag,
  output var  logic        zero_flag,
  output var  logic [13:0] third_indirect_pointer,
  output var  logic        return_strobe,
  output var  logic        busy
);
  import xoe_pkg::*;
  // ****************************************
  // Combinational decode.
  // ****************************************
  logic        is_xor_lit;
  logic        is_xor_file;
  logic        is_ptr_add;
  logic        is_ptr_sub;
  logic        ext_on;
  logic        indexed;
  logic [13:0] op_addr;
  logic [7:0]  xor_res;
  logic        accept;

  xoe_state_type state_reg;
  xoe_state_type state_next;
  logic [7:0]  acc_reg;
  logic [7:0]  acc_next;
  logic        neg_reg;
  logic        neg_next;
  logic        zero_reg;
  logic        zero_next;
  logic [13:0] ptr_reg;
  logic [13:0] ptr_next;
  logic [13:0] addr_reg;
  logic [13:0] addr_next;
  logic [7:0]  wdata_reg;
  logic [7:0]  wdata_next;
  logic        we_reg;
  logic        we_next;
  logic        ret_reg;
  logic        ret_next;

  always_comb begin
    ext_on      = extension_enable_fuse;
    accept      = instr_valid && (state_reg == XOE_ST_RUN);
    is_xor_lit  = accept && (instr_word[15:8] == XOE_OP_XOR_LIT);
    is_xor_file = accept && (instr_word[15:10] == XOE_OP_XOR_FILE);
    is_ptr_add  = accept && ext_on && (instr_word[15:8] == XOE_OP_ADD_PTR)
                  && (instr_word[7:6] == XOE_PTR_SEL_THIRD);
    is_ptr_sub  = accept && ext_on && (instr_word[15:8] == XOE_OP_SUB_PTR)
                  && (instr_word[7:6] == XOE_PTR_SEL_THIRD);
    indexed     = ext_on && !instr_word[XOE_BIT_BANK]
                  && (instr_word[7:0] <= XOE_INDEX_MAX);
    if (indexed) begin
      op_addr = ptr_reg + {6'h00, instr_word[7:0]};
    end else if (instr_word[XOE_BIT_BANK]) begin
      op_addr = {bank_select_register, instr_word[7:0]};
    end else if (instr_word[7:0] >= XOE_ACCESS_SFR_LO) begin
      op_addr = {XOE_ACCESS_SFR_BNK, instr_word[7:0]};
    end else begin
      op_addr = {6'h00, instr_word[7:0]};
    end
    if (is_xor_lit) begin
      xor_res = acc_reg ^ instr_word[7:0];
    end else begin
      xor_res = acc_reg ^ file_rdata;
    end
  end

  // ****************************************
  // Next state.
  // ****************************************
  always_comb begin
    state_next = XOE_ST_RUN;
    acc_next   = acc_reg;
    neg_next   = neg_reg;
    zero_next  = zero_reg;
    ptr_next   = ptr_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    we_next    = 1'b0;
    ret_next   = 1'b0;
    unique case (state_reg)
      XOE_ST_RUN: begin
        if (is_xor_lit || is_xor_file) begin
          neg_next  = xor_res[XOE_BIT_NEG];
          zero_next = (xor_res == 8'h00);
          wdata_next = xor_res;
          if (is_xor_file) begin
            addr_next = op_addr;
          end
          if (is_xor_file && instr_word[XOE_BIT_DEST]) begin
            we_next = 1'b1;
          end else begin
            acc_next = xor_res;
          end
        end else if (is_ptr_add) begin
          ptr_next   = ptr_reg + {8'h00, instr_word[5:0]};
          state_next = XOE_ST_RETURN;
        end else if (is_ptr_sub) begin
          ptr_next   = ptr_reg - {8'h00, instr_word[5:0]};
          state_next = XOE_ST_RETURN;
        end
      end
      XOE_ST_RETURN: begin
        ret_next = 1'b1;
      end
      default: begin
        state_next = XOE_ST_RUN;
      end
    endcase
  end

  // ****************************************
  // Registers.
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= XOE_ST_RUN;
      acc_reg   <= XOE_ACC_RST;
      neg_reg   <= 1'b0;
      zero_reg  <= 1'b0;
      ptr_reg   <= XOE_PTR_RST;
      addr_reg  <= XOE_PTR_RST;
      wdata_reg <= XOE_ACC_RST;
      we_reg    <= 1'b0;
      ret_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      neg_reg   <= neg_next;
      zero_reg  <= zero_next;
      ptr_reg   <= ptr_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      we_reg    <= we_next;
      ret_reg   <= ret_next;
    end
  end

  assign accumulator            = acc_reg;
  assign neg_flag               = neg_reg;
  assign zero_flag              = zero_reg;
  assign third_indirect_pointer = ptr_reg;
  assign file_addr              = addr_reg;
  assign file_wdata             = wdata_reg;
  assign file_we                = we_reg;
  assign return_strobe          = ret_reg;
  assign busy                   = (state_reg == XOE_ST_RETURN);
endmodule : xoe_core
`default_nettype wire

// ===== src/xoe_pkg.sv
`default_nettype none
package xoe_pkg;
  // ****************************************
  // Opcode patterns.
  // ****************************************
  localparam logic [7:0] XOE_OP_XOR_LIT     = 8'h0A;
  localparam logic [5:0] XOE_OP_XOR_FILE    = 6'h06;
  localparam logic [7:0] XOE_OP_ADD_PTR     = 8'hE8;
  localparam logic [7:0] XOE_OP_SUB_PTR     = 8'hE9;
  localparam logic [1:0] XOE_PTR_SEL_THIRD  = 2'h3;
  localparam logic [7:0] XOE_INDEX_MAX      = 8'h5F;
  localparam logic [7:0] XOE_ACCESS_SFR_LO  = 8'h60;
  localparam logic [5:0] XOE_ACCESS_SFR_BNK = 6'h3F;
  // ****************************************
  // Reset values and field positions.
  // ****************************************
  localparam logic [7:0]  XOE_ACC_RST  = 8'h00;
  localparam logic [13:0] XOE_PTR_RST  = 14'h0000;
  localparam int          XOE_BIT_DEST = 9;
  localparam int          XOE_BIT_BANK = 8;
  localparam int          XOE_BIT_NEG  = 7;
  typedef enum logic [1:0] {
    XOE_ST_RUN    = 2'b00,
    XOE_ST_RETURN = 2'b01
  } xoe_state_type;
endpackage : xoe_pkg
`default_nettype wire

// ===== src/xoe_unused.sv
`default_nettype none
`default_nettype wire

// ===== test/xoe_chk.sv
`default_nettype none
module xoe_chk
  import xoe_pkg::*;
(
  input wire logic        ref_clk, rst_b, instr_valid, extension_enable_fuse, file_we, neg_flag, zero_flag,
  input wire logic        return_strobe, busy,
  input wire logic [15:0] instr_word,
  input wire logic [5:0]  bank_select_register,
  input wire logic [7:0]  file_rdata, file_wdata, accumulator,
  input wire logic [13:0] file_addr, third_indirect_pointer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic tk  = instr_valid && !busy;
  wire logic lit = tk && instr_word[15:8] == XOE_OP_XOR_LIT;
  wire logic fop = tk && instr_word[15:10] == XOE_OP_XOR_FILE;
  wire logic low = fop && !instr_word[8] && instr_word[7:0] <= XOE_INDEX_MAX;
  wire logic pop = tk && extension_enable_fuse && instr_word[15:9] == XOE_OP_ADD_PTR[7:1] && instr_word[7:6] == 2'h3;
  AST_LIT: assert property (lit |=> accumulator == ($past(accumulator) ^ $past(instr_word[7:0])))
    else $error("literal xor result wrong");
  AST_FILE: assert property (fop |=> file_wdata == ($past(accumulator) ^ $past(file_rdata)))
    else $error("file xor result wrong");
  AST_DEST: assert property (fop |=> file_we == $past(instr_word[9]) && (file_we || accumulator == file_wdata))
    else $error("xor destination wrong");
  AST_BANK: assert property (fop && instr_word[8] |=> file_addr == {$past(bank_select_register), $past(instr_word[7:0])})
    else $error("banked address wrong");
  AST_IDX: assert property (low && extension_enable_fuse |=> file_addr == $past(third_indirect_pointer) + 14'($past(instr_word[7:0])))
    else $error("indexed address wrong");
  AST_NOEXT: assert property (low && !extension_enable_fuse |=> file_addr == 14'($past(instr_word[7:0])))
    else $error("direct access address wrong");
  AST_RET: assert property (pop |=> busy && !return_strobe ##1 return_strobe && !busy)
    else $error("pointer return timing wrong");
  AST_PFLAG: assert property (pop |=> $stable(neg_flag) && $stable(zero_flag))
    else $error("pointer op changed flags");
  AST_FLAG: assert property (lit |=> neg_flag == accumulator[7] && zero_flag == (accumulator == 8'h00))
    else $error("xor flags wrong");
endmodule : xoe_chk
bind xoe_core xoe_chk u_chk (.ref_clk, .rst_b, .instr_valid, .extension_enable_fuse, .file_we, .neg_flag, .zero_flag,
  .return_strobe, .busy, .instr_word, .bank_select_register, .file_rdata, .file_wdata, .accumulator, .file_addr,
  .third_indirect_pointer);
`default_nettype wire

// ===== test/xor_ops_and_extension_enable_bench.sv
`default_nettype none
module xor_ops_and_extension_enable_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 0, rst_b = 0, instr_valid = 0, extension_enable_fuse = 0, file_we, neg_flag, zero_flag;
  logic        return_strobe, busy, m_neg, m_zero, m_we, m_ret, m_busy, pw;
  logic [15:0] instr_word = 16'h0000, w;
  logic [5:0]  bank_select_register = 6'h00;
  logic [7:0]  file_rdata, file_wdata, accumulator, m_acc, m_wd, r;
  logic [13:0] file_addr, third_indirect_pointer, m_ptr, m_fa, fa;
  logic [7:0]  mem [0:16383];
  int          mismatches = 0, n_compared = 0;
  xoe_core u_dut (.ref_clk, .rst_b, .instr_valid, .instr_word, .extension_enable_fuse, .bank_select_register,
    .file_rdata, .file_addr, .file_wdata, .file_we, .accumulator, .neg_flag, .zero_flag, .third_indirect_pointer,
    .return_strobe, .busy);
  initial forever #25 ref_clk = ~ref_clk;
  always_comb begin
    fa = {6'h00, instr_word[7:0]};
    if (instr_word[8]) fa = {bank_select_register, instr_word[7:0]};
    else if (instr_word[7:0] > 8'h5F) fa = {6'h3F, instr_word[7:0]};
    else if (extension_enable_fuse) fa = m_ptr + instr_word[7:0];
  end
  assign file_rdata = mem[fa];
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic step(input logic [15:0] wd, input logic v, input logic f);
    @(posedge ref_clk);
    instr_word <= wd;
    instr_valid <= v;
    extension_enable_fuse <= f;
    bank_select_register <= 6'($urandom);
    #1;
    n_compared++;
    if ({accumulator, neg_flag, zero_flag, third_indirect_pointer, file_we, return_strobe, busy, file_addr, file_wdata}
        !== {m_acc, m_neg, m_zero, m_ptr, m_we, m_ret, m_busy, m_fa, m_wd}) begin
      mismatches++;
      $display("wrong value at %0t: core state differs", $time);
    end
    if (pw) mem[m_fa] = m_wd;
    {pw, m_we, m_ret, m_busy} = {2'b00, m_busy, 1'b0};
    if (v && !m_ret && wd[15:8] == 8'h0A) begin
      r = m_acc ^ wd[7:0];
      {m_acc, m_neg, m_zero, m_wd} = {r, r[7], r == 8'h00, r};
    end else if (v && !m_ret && wd[15:10] == 6'h06) begin
      r = m_acc ^ mem[fa];
      {m_fa, m_neg, m_zero, m_wd, m_we, pw} = {fa, r[7], r == 8'h00, r, wd[9], wd[9]};
      if (!wd[9]) m_acc = r;
    end else if (v && !m_ret && f && wd[15:9] == 7'h74 && wd[7:6] == 2'b11) begin
      m_ptr = wd[8] ? m_ptr - wd[5:0] : m_ptr + wd[5:0];
      m_busy = 1'b1;
    end
  endtask : step
  initial begin
    void'($urandom(32'hB12436E6));
    foreach (mem[i]) mem[i] = 8'($urandom);
    mem[16] = 8'hAF;
    {m_acc, m_neg, m_zero, m_ptr, m_we, m_ret, m_busy, m_fa, m_wd, pw} = '0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (16) step({4'h0, 12'h000}, 1'b0, 1'b0);
    step(16'h0AB5, 1, 1);
    step(16'h1A10, 1, 1);
    step(16'h0AAF, 1, 1);
    step(16'hE8C5, 1, 1);
    step(16'h1A10, 1, 1);
    step(16'hE9C1, 1, 0);
    $display("test directed done");
    repeat (3000) begin
      case ($urandom % 4)
        0: w = {8'h0A, 8'($urandom)};
        1: w = {6'h06, 10'($urandom)};
        2: w = {7'h74, 1'($urandom), 2'b11, 6'($urandom)};
        default: w = 16'($urandom);
      endcase
      step(w, ($urandom % 8) != 0, 1'($urandom));
    end
    $display("test random done");
    final_report;
  end
  initial begin
    #400000;
    mismatches++;
    final_report;
  end
endmodule : xor_ops_and_extension_enable_bench
`default_nettype wire
